// File: taa_adder.sv
// Purpose: 24-bit three-input address adder with carry-save and lookahead stages
// Assumes: inputs synchronous to sys_clk; result registered one cycle after merge
// Notes: sum parity is predicted only; the consumer checks the sum against it
`default_nettype none
module taa_adder
    import taa_pkg::*;
#(
    parameter int ADDR_W = TAA_ADDR_W,
    parameter int GRP_W = TAA_GRP_W
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire taa_pkg::taa_bus_t [1:0] left_src,
    input wire taa_pkg::taa_bus_t [1:0] right_src,
    input wire logic [TAA_LEN_W-1:0] vfl_length,
    input wire logic [TAA_DISP_W-1:0] iop_disp,
    input wire logic [TAA_IMPL_W-1:0] intr_implied,
    output taa_pkg::taa_bus_t left_general_bus,
    output taa_pkg::taa_bus_t right_general_bus,
    output logic [TAA_MASK_W-1:0] program_mask,
    output logic [TAA_XOP_W-1:0] execute_operand,
    output taa_pkg::taa_res_t result
);
    import taa_pkg::*;
    localparam int GRP_N = ADDR_W / GRP_W;
    if (ADDR_W != TAA_ADDR_W || ADDR_W % GRP_W != 0) begin : g_chk
        $error("taa_adder: width must be 24 and a multiple of the group width");
    end

    typedef struct packed {
        taa_res_t r;
    } taa_st_t;
    taa_st_t st_q, st_d;

    taa_bus_t lm, rm;
    // merge both buses; bits 0-7 are still merged for the fan-out
    // left and right merge
    taa_merge #(.SRC_N(2)) u_left (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .src(left_src),
        .merged(lm)
    );
    taa_merge #(.SRC_N(2)) u_right (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .src(right_src),
        .merged(rm)
    );

    // full 36 bits out to the bus latch gating
    assign left_general_bus = lm;
    assign right_general_bus = rm;
    // program mask is bus bits 2-7 (vector bits 29:24)
    assign program_mask = lm.data[TAA_MASK_LSB +: TAA_MASK_W];
    // bus bits 24-31 to the operation register
    assign execute_operand = lm.data[TAA_XOP_LSB +: TAA_XOP_W];

    logic [ADDR_W-1:0] op_a, op_b, op_c;
    logic [ADDR_W-1:0] cs_sum, cs_car, pa_b, g, t, hs, c_bit;
    logic [GRP_N:0] c_grp;
    logic hs_pred, hs_gen, sum_pred, la_err;

    // only bus bits 8-31 take part
    // index or length plus base plus displacement
    always_comb begin
        op_a = lm.data[ADDR_W-1:0];
        op_b = rm.data[ADDR_W-1:0] | {{(ADDR_W-TAA_LEN_W){1'b0}}, vfl_length};
        // displacement or interrupt implied bits 25-28
        op_c = {{(ADDR_W-TAA_DISP_W){1'b0}}, iop_disp};
        op_c[TAA_IMPL_LSB +: TAA_IMPL_W] = op_c[TAA_IMPL_LSB +: TAA_IMPL_W] | intr_implied;
    end

    assign cs_sum = op_a ^ op_b ^ op_c;
    // majority carry, shifted one place up; top carry drops out of 24 bits
    assign cs_car = (op_a & op_b) | (op_a & op_c) | (op_b & op_c);
    assign pa_b = {cs_car[ADDR_W-2:0], 1'b0};
    assign g = cs_sum & pa_b;
    assign t = cs_sum | pa_b;
    assign hs = cs_sum ^ pa_b;

    // group lookahead carries; bit carries ripple only within a group
    always_comb begin
        logic gg, gt;
        gg = 1'b0;
        gt = 1'b1;
        c_grp = '0;
        c_bit = '0;
        for (int k = 0; k < GRP_N; k++) begin
            gg = 1'b0;
            gt = 1'b1;
            for (int j = 0; j < GRP_W; j++) begin
                gg = g[k*GRP_W+j] | (t[k*GRP_W+j] & gg);
                gt = gt & t[k*GRP_W+j];
            end
            c_grp[k+1] = gg | (gt & c_grp[k]);
        end
        for (int k = 0; k < GRP_N; k++) begin
            c_bit[k*GRP_W] = c_grp[k];
            for (int j = 1; j < GRP_W; j++) begin
                c_bit[k*GRP_W+j] = g[k*GRP_W+j-1] | (t[k*GRP_W+j-1] & c_bit[k*GRP_W+j-1]);
            end
        end
    end

    // group carry-in versus top-bit carry of the group below
    always_comb begin
        la_err = 1'b0;
        for (int k = 1; k < GRP_N; k++) begin
            la_err = la_err | (c_grp[k] !=
                (g[k*GRP_W-1] | (t[k*GRP_W-1] & c_bit[k*GRP_W-1])));
        end
    end

    assign hs_pred = (^cs_sum) ^ (^pa_b);
    assign hs_gen = ^hs;
    // duplicate bit lookahead
    // a second carry chain costs gates, but a fault in c_bit now shows as a parity slip
    always_comb begin
        logic dc;
        dc = 1'b0;
        sum_pred = ^hs;
        for (int k = 0; k < GRP_N; k++) begin
            dc = c_grp[k];
            for (int j = 0; j < GRP_W; j++) begin
                sum_pred = sum_pred ^ dc;
                dc = g[k*GRP_W+j] | (t[k*GRP_W+j] & dc);
            end
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.r.sum = hs ^ c_bit;
        st_d.r.sum_par = sum_pred;
        st_d.r.half_err = hs_pred != hs_gen;
        st_d.r.carry_err = la_err;
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    // sum_par travels with the sum for the consumer's check
    assign result = st_q.r;

    // helper: sum of this cycle's operands, compared with result one cycle later
    logic [ADDR_W-1:0] exp_sum;
    assign exp_sum = ADDR_W'(op_a + op_b + op_c);

    property p_sum;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 1'b1 |-> result.sum == $past(exp_sum);
    endproperty
    a_sum: assert property (p_sum) else $error("address sum wrong");
    property p_par;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 1'b1 |-> result.sum_par == ^result.sum;
    endproperty
    a_par: assert property (p_par) else $error("predicted sum parity wrong");
    property p_nohalf;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 1'b1 |-> !result.half_err;
    endproperty
    a_nohalf: assert property (p_nohalf) else $error("half-sum parity error");
    property p_nocarry;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 1'b1 |-> !result.carry_err;
    endproperty
    a_nocarry: assert property (p_nocarry) else $error("lookahead carry error");
    property p_csa;
        @(posedge sys_clk) disable iff (!rstn)
        ADDR_W'(cs_sum + {cs_car[ADDR_W-2:0], 1'b0}) == exp_sum;
    endproperty
    a_csa: assert property (p_csa) else $error("carry-save stage wrong");
    property p_mask;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 1'b1 |-> program_mask == $past(left_src[0].data[29:24] | left_src[1].data[29:24]);
    endproperty
    a_mask: assert property (p_mask) else $error("program mask wrong");
    property p_xop;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 1'b1 |-> execute_operand == $past(left_src[0].data[7:0] | left_src[1].data[7:0]);
    endproperty
    a_xop: assert property (p_xop) else $error("execute operand wrong");
    property p_len;
        @(posedge sys_clk) disable iff (!rstn)
        (vfl_length != 0) |-> (op_b[TAA_LEN_W-1:0] & vfl_length) == vfl_length;
    endproperty
    a_len: assert property (p_len) else $error("length not merged");
    property p_lbus;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 1'b1 |-> left_general_bus == $past(left_src[0] | left_src[1]);
    endproperty
    a_lbus: assert property (p_lbus) else $error("left bus merge wrong");
    property p_rbus;
        @(posedge sys_clk) disable iff (!rstn)
        ##1 1'b1 |-> right_general_bus == $past(right_src[0] | right_src[1]);
    endproperty
    a_rbus: assert property (p_rbus) else $error("right bus merge wrong");
    property p_disp;
        @(posedge sys_clk) disable iff (!rstn)
        (op_c[ADDR_W-1:TAA_DISP_W] == '0) &&
            ((op_c[TAA_IMPL_LSB +: TAA_IMPL_W] & intr_implied) == intr_implied);
    endproperty
    a_disp: assert property (p_disp) else $error("displacement operand wrong");
endmodule
`default_nettype wire

// File: taa_pkg.sv
// Purpose: shared constants and carriers for the three-input address adder
// Assumes: big-endian bit numbering on the buses, bit 0 is the high-order bit
// Notes: address field is bus bits 8..31, held as [23:0] with 0 the low-order bit
`default_nettype none
package taa_pkg;
    localparam int TAA_BUS_W = 32;
    localparam int TAA_PAR_W = 4;
    localparam int TAA_ADDR_W = 24;
    localparam int TAA_GRP_W = 4;
    localparam int TAA_LEN_W = 9;
    localparam int TAA_DISP_W = 12;
    localparam int TAA_IMPL_W = 4;
    localparam int TAA_IMPL_LSB = 3;
    localparam int TAA_MASK_W = 6;
    localparam int TAA_MASK_LSB = 24;
    localparam int TAA_XOP_W = 8;
    localparam int TAA_XOP_LSB = 0;
    localparam int TAA_HIGH_W = 8;
    // one general bus merge result: data bits with byte parity
    typedef struct packed {
        logic [TAA_BUS_W-1:0] data;
        logic [TAA_PAR_W-1:0] par;
    } taa_bus_t;
    // adder result with its checks
    typedef struct packed {
        logic [TAA_ADDR_W-1:0] sum;
        logic sum_par;
        logic half_err;
        logic carry_err;
    } taa_res_t;
endpackage
`default_nettype wire

// File: taa_merge.sv
// Purpose: final OR of one general bus from its sources
// Assumes: sources drive zero when not gated
// Notes: output registered, feeds adder and fan-out
`default_nettype none
module taa_merge
    import taa_pkg::*;
#(
    parameter int SRC_N = 2
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire taa_pkg::taa_bus_t [SRC_N-1:0] src,
    output taa_pkg::taa_bus_t merged
);
    import taa_pkg::*;
    typedef struct packed {
        taa_bus_t m;
    } taa_mst_t;
    taa_mst_t st_q, st_d;
    if (SRC_N < 1) begin : g_chk
        $error("taa_merge needs at least one source");
    end
    // wired-or of every source
    always_comb begin
        st_d = '0;
        for (int i = 0; i < SRC_N; i++) begin
            st_d.m = st_d.m | src[i];
        end
    end
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign merged = st_q.m;
endmodule
`default_nettype wire

// File: taa_consumer.sv
// Purpose: sum consumer at the far side, checks delivered sum parity
// Assumes: result is settled after each rising edge
// Notes: flags are combinational so the bench samples them with the sum
`default_nettype none
module taa_consumer
    import taa_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire taa_pkg::taa_res_t result,
    output logic par_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        par_bad = rstn && ((^result.sum) != result.sum_par);
    end
endmodule
`default_nettype wire

// File: test_three_input_address_adder.sv
// Purpose: self-checking bench for the address adder
// Assumes: sources driven at the falling edge, side inputs one cycle later
// Notes: one note per cycle, merge of this op and sum of the previous op
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_three_input_address_adder;
    import taa_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {taa_bus_t l; taa_bus_t r; logic [23:0] sum; bit rv;} taa_note_t;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    taa_bus_t [1:0] left_src = '0;
    taa_bus_t [1:0] right_src = '0;
    logic [8:0] vfl_length = '0;
    logic [11:0] iop_disp = '0;
    logic [3:0] intr_implied = '0;
    taa_bus_t left_general_bus;
    taa_bus_t right_general_bus;
    logic [5:0] program_mask;
    logic [7:0] execute_operand;
    taa_res_t result;
    logic par_bad;
    int fails = 0;
    int total_checks = 0;
    int seed = 34;
    taa_note_t notes[$];
    taa_note_t mn;
    taa_bus_t pl;
    taa_bus_t pr;
    bit have = 0;
    always #4 sys_clk = ~sys_clk;
    taa_adder uut (.sys_clk(sys_clk), .rstn(rstn), .left_src(left_src),
        .right_src(right_src), .vfl_length(vfl_length), .iop_disp(iop_disp),
        .intr_implied(intr_implied), .left_general_bus(left_general_bus),
        .right_general_bus(right_general_bus), .program_mask(program_mask),
        .execute_operand(execute_operand), .result(result));
    taa_consumer u_cons (.sys_clk(sys_clk), .rstn(rstn), .result(result), .par_bad(par_bad));
    function automatic taa_bus_t rnd_bus();
        return {$random(seed), 4'($random(seed))};
    endfunction
    // sum note uses the previous merge with this cycle's side inputs
    task automatic step(input taa_bus_t a0, input taa_bus_t a1, input taa_bus_t b0,
        input taa_bus_t b1, input logic [8:0] len, input logic [11:0] d, input logic [3:0] im);
        taa_note_t n;
        logic [31:0] r;
        @(negedge sys_clk);
        r = pr.data | {23'h0, len};
        n.sum = pl.data[23:0] + r[23:0] + ({12'h0, d} | {17'h0, im, 3'h0});
        n.l = a0 | a1;
        n.r = b0 | b1;
        n.rv = have;
        notes.push_back(n);
        left_src = {a1, a0};
        right_src = {b1, b0};
        vfl_length = len;
        iop_disp = d;
        intr_implied = im;
        pl = n.l;
        pr = n.r;
        have = 1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // monitor: oldest note against settled outputs
    always @(posedge sys_clk) begin
        #1;
        if (rstn && notes.size() > 0) begin
            mn = notes.pop_front();
            `CHK("left_bus", mn.l, left_general_bus)
            `CHK("right_bus", mn.r, right_general_bus)
            `CHK("mask", mn.l.data[29:24], program_mask)
            `CHK("xop", mn.l.data[7:0], execute_operand)
            if (mn.rv) begin
                `CHK("sum", mn.sum, result.sum)
                `CHK("sum_par", ^mn.sum, result.sum_par)
                `CHK("half_err", 1'b0, result.half_err)
                `CHK("carry_err", 1'b0, result.carry_err)
                `CHK("consumer", 1'b0, par_bad)
            end
        end
    end
    // watchdog well beyond the expected few hundred cycles
    initial begin
        #(3000 * 8);
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        repeat (200) step(rnd_bus(), rnd_bus(), rnd_bus(), rnd_bus(), 9'($random(seed)),
            12'($random(seed)), 4'($random(seed)));
        $display("random operands done");
        step('1, '1, '1, '1, '1, '1, '0);
        step('0, '0, '0, '0, '1, '1, '1);
        for (int i = 0; i < 16; i++) step(rnd_bus(), '0, rnd_bus(), '0, '0, '0, 4'(i));
        $display("boundaries and implied codes done");
        // reset in mid-run clears outputs
        @(negedge sys_clk);
        rstn = 1'b0;
        notes.delete();
        have = 0;
        @(posedge sys_clk);
        #1;
        `CHK("reset_sum", 24'h0, result.sum)
        `CHK("reset_bus", 36'h0, left_general_bus)
        @(negedge sys_clk);
        rstn = 1'b1;
        repeat (20) step(rnd_bus(), rnd_bus(), rnd_bus(), rnd_bus(), 9'($random(seed)),
            12'($random(seed)), 4'($random(seed)));
        step('0, '0, '0, '0, '0, '0, '0);
        repeat (2) @(posedge sys_clk);
        #2;
        $display("reset and restart done");
        report_and_stop();
    end
endmodule
`default_nettype wire
